// >>> verilog/actc_map.svh
/*
 converter timing constants, register offsets and field positions.
 assumes inclusion by the package and by the design modules.
*/
`ifndef ACTC_MAP_SVH
`define ACTC_MAP_SVH
`define ACTC_OFS_CONTROL     4'h0
`define ACTC_OFS_SYSCFG      4'h1
`define ACTC_OFS_MCCFG       4'h2
`define ACTC_OFS_STATUS      4'h3
`define ACTC_OFS_RESULT      4'h4
`define ACTC_OFS_INPUT       4'h5
`define ACTC_CTL_RESET       16'h0000
`define ACTC_DIV_HI          15
`define ACTC_DIV_LO          14
`define ACTC_STC_HI          13
`define ACTC_STC_LO          12
`define ACTC_BIT_ALTCLK      11
`define ACTC_BIT_POSTCAL     10
`define ACTC_BIT_MODE8       9
`define ACTC_BIT_START       8
`define ACTC_ALT_HI          7
`define ACTC_ALT_LO          0
`define ACTC_RESOLVE10       8'h28
`define ACTC_RESOLVE8        8'h20
`define ACTC_POSTCAL_BC      8'h0c
`define ACTC_LOAD_SYS        4'h6
`define ACTC_CAL_MIN_BC      16'h01e4
`define ACTC_CAL_MAX_BC      16'h2db0
`define ACTC_CODE_ZERO       10'h000
`define ACTC_CODE_FULL       10'h3ff
`endif

// >>> verilog/actc_pkg.sv
/*
 types shared by the converter timing control.
 assumes actc_map.svh sits next to it.
*/
`include "actc_map.svh"
package actc_pkg;
    typedef enum logic [2:0] {
        ACTC_IDLE, ACTC_SAMPLE, ACTC_RESOLVE, ACTC_POSTCAL, ACTC_LOAD
    } actc_phase_type;
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } actc_bus_type;
    typedef struct packed {
        logic        below;  // input under reference ground
        logic        above;  // input over reference supply
        logic [9:0]  code;   // raw approximation code
    } actc_analog_type;
endpackage

// >>> verilog/actc_clkgen.sv
/*
 derives the cpu and system clock enables from the master clock tick.
 assumes master ticks come from the configured prescaler or pll, one per master period.
*/
`timescale 1ns/10ps
module actc_clkgen
    import actc_pkg::*;
(
    input  wire logic REF_CLK,
    input  wire logic rst_n,
    input  wire logic cpu_clock_halving,
    input  wire logic mc_tick,
    output logic      sys_tick
);
    logic half;
    logic next_half;
    logic next_sys_tick;

    // cpu clock equals master or master/2, system clock follows cpu
    always_comb
    begin
        next_half     = half;
        next_sys_tick = 1'b0;
        if (mc_tick)
        begin
            next_half     = ~half;
            next_sys_tick = ~cpu_clock_halving | half;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            half     <= 1'b0;
            sys_tick <= 1'b0;
        end
        else
        begin
            half     <= next_half;
            sys_tick <= next_sys_tick;
        end
    end

    sys_rate_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        (sys_tick && cpu_clock_halving) |=> !sys_tick)
        else $error("halved system clock ticked twice in a row");
endmodule

// >>> verilog/actc_top.sv
/*
 converter timing control: clock derivation, sample and conversion sequencing,
 result saturation and reset calibration window.
 assumes a plain register port and an analog front end that reports its code.
*/
// Design decisions made here: the strobed register port and the address map.
// How it works
// - compatibility divider codes 00..11 give system clock over 4, 2, 16, 8
// - sample lasts 8, 16, 32 or 64 basic clocks by sample select
// - ten-bit conversion: sample plus 52 or 40 basic clocks plus six system
// - eight-bit conversion: sample plus 44 or 32 basic clocks plus six system
// - dropping post-calibration removes exactly twelve basic clocks
// - each conversion ends loading the result, inside the six system clocks
// - input below ground gives all zeros, above supply gives all ones
// - after reset calibration runs 484 to 11696 basic clocks
// - conversions during calibration run and lengthen remaining calibration
// - cpu clock is master clock or half of it by one bit
// - peripherals run on a system clock equal to cpu clock
// - master clock configuration picks how master clock is derived
// - an alternative programmable basic clock divider is selectable
`timescale 1ns/10ps
`include "actc_map.svh"
module actc_top
    import actc_pkg::*;
#(
    parameter int CAL_MAX_BC = 11696
)
(
    input  wire logic            REF_CLK,
    input  wire logic            RST_N,
    input  wire actc_pkg::actc_bus_type    BUS,
    output logic [15:0]          RDATA,
    input  wire actc_pkg::actc_analog_type ANALOG,
    input  wire logic            REF_NOISE,
    output logic                 BUSY,
    output logic                 CAL_RUNNING,
    output logic [9:0]           RESULT
);
    import actc_pkg::*;

    // reset release through two flops
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // register state
    logic [15:0] control;
    logic        sys_cfg;
    logic [1:0]  mc_cfg;
    logic [15:0] next_control;
    logic        next_sys_cfg;
    logic [1:0]  next_mc_cfg;
    logic [15:0] next_rdata;
    logic        start_req;

    // register writes and read mux
    always_comb
    begin
        next_control = control;
        next_sys_cfg = sys_cfg;
        next_mc_cfg  = mc_cfg;
        next_rdata   = 16'h0000;
        start_req    = 1'b0;
        if (BUS.wr)
        begin
            unique case (BUS.addr)
                `ACTC_OFS_CONTROL:
                begin
                    next_control = BUS.wdata;
                    next_control[`ACTC_BIT_START] = 1'b0; // start self clears
                    start_req = BUS.wdata[`ACTC_BIT_START];
                end
                `ACTC_OFS_SYSCFG: next_sys_cfg = BUS.wdata[0];
                `ACTC_OFS_MCCFG:  next_mc_cfg  = BUS.wdata[1:0];
                default:          next_control = control;
            endcase
        end
        if (BUS.rd)
        begin
            unique case (BUS.addr)
                `ACTC_OFS_CONTROL: next_rdata = control;
                `ACTC_OFS_SYSCFG:  next_rdata = {15'h0000, sys_cfg};
                `ACTC_OFS_MCCFG:   next_rdata = {14'h0000, mc_cfg};
                `ACTC_OFS_STATUS:  next_rdata = {14'h0000, CAL_RUNNING, BUSY};
                `ACTC_OFS_RESULT:  next_rdata = {6'h00, RESULT};
                default:           next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control <= `ACTC_CTL_RESET;
            sys_cfg <= 1'b0;
            mc_cfg  <= 2'h0;
            RDATA   <= 16'h0000;
        end
        else
        begin
            control <= next_control;
            sys_cfg <= next_sys_cfg;
            mc_cfg  <= next_mc_cfg;
            RDATA   <= next_rdata;
        end
    end

    // master clock derivation: 0 direct, 1 prescale by 2, 2 by 4, 3 locked loop as direct
    logic [1:0] mc_cnt;
    logic [1:0] next_mc_cnt;
    logic       mc_tick;
    always_comb
    begin
        next_mc_cnt = mc_cnt + 2'h1;
        unique case (mc_cfg)
            2'h1:    mc_tick = (mc_cnt[0] == 1'b1);
            2'h2:    mc_tick = (mc_cnt == 2'h3);
            default: mc_tick = 1'b1;
        endcase
    end
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
            mc_cnt <= 2'h0;
        else
            mc_cnt <= next_mc_cnt;
    end

    logic sys_tick;
    actc_clkgen u_clkgen (
        .REF_CLK           (REF_CLK),
        .rst_n             (rst_n),
        .cpu_clock_halving (sys_cfg),
        .mc_tick           (mc_tick),
        .sys_tick          (sys_tick)
    );

    // divider ratio from compatibility codes or the alternative field
    function automatic logic [8:0] div_ratio(input logic [15:0] c);
        logic [8:0] r;
        r = 9'h004;
        if (c[`ACTC_BIT_ALTCLK])
            r = {1'b0, c[`ACTC_ALT_HI:`ACTC_ALT_LO]} + 9'h001;
        else
        begin
            unique case (c[`ACTC_DIV_HI:`ACTC_DIV_LO])
                2'h0: r = 9'h004;
                2'h1: r = 9'h002;
                2'h2: r = 9'h010;
                2'h3: r = 9'h008;
            endcase
        end
        return r;
    endfunction

    // sequencer phase, declared early since the basic clock restarts on a start
    actc_phase_type phase;
    actc_phase_type next_phase;

    // basic clock tick from system ticks
    logic [8:0] bc_cnt;
    logic [8:0] next_bc_cnt;
    logic       bc_tick;
    always_comb
    begin
        next_bc_cnt = bc_cnt;
        bc_tick     = 1'b0;
        if (sys_tick)
        begin
            if (bc_cnt + 9'h001 >= div_ratio(control))
            begin
                next_bc_cnt = 9'h000;
                bc_tick     = 1'b1;
            end
            else
                next_bc_cnt = bc_cnt + 9'h001;
        end
        // a start restarts the basic clock, so the conversion length is exact to within one system period
        if (start_req && phase == ACTC_IDLE)
            next_bc_cnt = 9'h000;
    end
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
            bc_cnt <= 9'h000;
        else
            bc_cnt <= next_bc_cnt;
    end

    // conversion sequencer
    logic [7:0]  ph_cnt;
    logic [7:0]  next_ph_cnt;
    logic [9:0]  next_result;
    logic        next_busy;
    logic        mode8;
    logic        postcal;
    logic        next_mode8;
    logic        next_postcal;
    logic [7:0]  sample_len;
    logic [7:0]  resolve_len;

    always_comb
    begin
        unique case (control[`ACTC_STC_HI:`ACTC_STC_LO])
            2'h0: sample_len = 8'h08;
            2'h1: sample_len = 8'h10;
            2'h2: sample_len = 8'h20;
            2'h3: sample_len = 8'h40;
        endcase
        resolve_len = mode8 ? `ACTC_RESOLVE8 : `ACTC_RESOLVE10;
    end

    always_comb
    begin
        next_phase   = phase;
        next_ph_cnt  = ph_cnt;
        next_result  = RESULT;
        next_mode8   = mode8;
        next_postcal = postcal;
        unique case (phase)
            ACTC_IDLE:
                if (start_req)
                begin
                    next_phase   = ACTC_SAMPLE;
                    next_ph_cnt  = 8'h00;
                    next_mode8   = BUS.wdata[`ACTC_BIT_MODE8];
                    next_postcal = BUS.wdata[`ACTC_BIT_POSTCAL];
                end
            ACTC_SAMPLE:
                if (bc_tick)
                begin
                    next_ph_cnt = ph_cnt + 8'h01;
                    if (ph_cnt + 8'h01 == sample_len)
                    begin
                        next_phase  = ACTC_RESOLVE;
                        next_ph_cnt = 8'h00;
                    end
                end
            ACTC_RESOLVE:
                if (bc_tick)
                begin
                    next_ph_cnt = ph_cnt + 8'h01;
                    if (ph_cnt + 8'h01 == resolve_len)
                    begin
                        next_phase  = postcal ? ACTC_POSTCAL : ACTC_LOAD;
                        next_ph_cnt = 8'h00;
                    end
                end
            ACTC_POSTCAL:
                if (bc_tick)
                begin
                    next_ph_cnt = ph_cnt + 8'h01;
                    if (ph_cnt + 8'h01 == `ACTC_POSTCAL_BC)
                    begin
                        next_phase  = ACTC_LOAD;
                        next_ph_cnt = 8'h00;
                    end
                end
            ACTC_LOAD:
                if (sys_tick)
                begin
                    next_ph_cnt = ph_cnt + 8'h01;
                    if (ph_cnt + 8'h01 == {4'h0, `ACTC_LOAD_SYS})
                    begin
                        next_phase  = ACTC_IDLE;
                        next_ph_cnt = 8'h00;
                        if (ANALOG.below)
                            next_result = `ACTC_CODE_ZERO;
                        else if (ANALOG.above)
                            next_result = `ACTC_CODE_FULL;
                        else if (mode8)
                            next_result = {ANALOG.code[9:2], 2'h0};
                        else
                            next_result = ANALOG.code;
                    end
                end
        endcase
        next_busy = (next_phase != ACTC_IDLE);
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase   <= ACTC_IDLE;
            ph_cnt  <= 8'h00;
            RESULT  <= 10'h000;
            BUSY    <= 1'b0;
            mode8   <= 1'b0;
            postcal <= 1'b0;
        end
        else
        begin
            phase   <= next_phase;
            ph_cnt  <= next_ph_cnt;
            RESULT  <= next_result;
            BUSY    <= next_busy;
            mode8   <= next_mode8;
            postcal <= next_postcal;
        end
    end

    // noise flag comes from the analog side: three flops, taken once two agree
    logic [2:0] noise_sync;
    logic       noise_q;
    logic       next_noise_q;
    always_comb
    begin
        next_noise_q = noise_q;
        if (noise_sync[2] == noise_sync[1])
            next_noise_q = noise_sync[2];
    end
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            noise_sync <= 3'h0;
            noise_q    <= 1'b0;
        end
        else
        begin
            noise_sync <= {noise_sync[1:0], REF_NOISE};
            noise_q    <= next_noise_q;
        end
    end

    // reset calibration: runs at least the minimum, ends when reference is quiet or at the maximum
    logic [15:0] cal_cnt;
    logic [15:0] next_cal_cnt;
    logic        next_cal_running;
    always_comb
    begin
        next_cal_cnt     = cal_cnt;
        next_cal_running = CAL_RUNNING;
        if (CAL_RUNNING && bc_tick)
        begin
            if (BUSY)
                next_cal_cnt = cal_cnt;
            else
                next_cal_cnt = cal_cnt + 16'h0001;
            if (next_cal_cnt >= 16'(CAL_MAX_BC) ||
                (next_cal_cnt >= `ACTC_CAL_MIN_BC && !noise_q))
                next_cal_running = 1'b0;
        end
    end
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_cnt     <= 16'h0000;
            CAL_RUNNING <= 1'b1;
        end
        else
        begin
            cal_cnt     <= next_cal_cnt;
            CAL_RUNNING <= next_cal_running;
        end
    end

    sample_order_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        (phase == ACTC_SAMPLE && next_phase == ACTC_RESOLVE)
            |-> (ph_cnt + 8'h01 == sample_len))
        else $error("sampling ended at wrong length");
    postcal_skip_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        (phase == ACTC_RESOLVE && !postcal) |=> phase != ACTC_POSTCAL)
        else $error("post-calibration ran while disabled");
    load_order_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        (phase == ACTC_IDLE && $past(phase) != ACTC_IDLE) |-> $past(phase) == ACTC_LOAD)
        else $error("conversion ended outside load phase");
    sat_low_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        (phase == ACTC_LOAD && next_phase == ACTC_IDLE && ANALOG.below)
            |=> RESULT == `ACTC_CODE_ZERO)
        else $error("low saturation missing");
    sat_high_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        (phase == ACTC_LOAD && next_phase == ACTC_IDLE && !ANALOG.below && ANALOG.above)
            |=> RESULT == `ACTC_CODE_FULL)
        else $error("high saturation missing");
    cal_min_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        $fell(CAL_RUNNING) |-> cal_cnt + 16'h0001 >= `ACTC_CAL_MIN_BC)
        else $error("calibration ended early");
    cal_hold_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        (CAL_RUNNING && BUSY) |=> $stable(cal_cnt))
        else $error("calibration advanced during conversion");
    div_tick_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        bc_tick |-> sys_tick)
        else $error("basic tick without system tick");
endmodule

// >>> verif/actc_afe_model.sv
/*
 analog front end model: turns a signed test level into the converter input struct.
 assumes levels in 1/1024 of the reference span, negative under ground, 1024 up over supply.
*/
`timescale 1ns/10ps
module actc_afe_model
    import actc_pkg::*;
(
    input  wire logic signed [11:0]  level,
    output actc_pkg::actc_analog_type analog
);
    import actc_pkg::*;
    // raw code wraps when out of range, so the converter must saturate it itself
    always_comb
    begin
        analog.below = level[11];
        analog.above = !level[11] && level[10];
        analog.code  = level[9:0];
    end
endmodule

// >>> verif/tb.sv
/*
 self-checking bench for the converter timing control.
 assumes a 40 MHz clock, calibration shortened to 600 basic clocks, bus as in the package.
*/
`timescale 1ns/10ps
module tb;
    import actc_pkg::*;
    typedef struct packed
    {
        logic [15:0] ctl;
        logic [11:0] vin;
        logic [9:0]  res;
    } actc_row_type;
    logic                   ref_clk;
    logic                   rst_n;
    logic                   ref_noise;
    logic                   busy;
    logic                   cal_running;
    logic [15:0]            rdata;
    logic [15:0]            rd_val;
    logic [9:0]             result;
    logic signed [11:0]     level;
    actc_bus_type           bus;
    actc_analog_type        analog;
    int                     cyc = 0;
    int                     t0;
    int                     tr;
    int                     d;
    int                     sf;
    int                     bad_count = 0;
    int                     cmp_count = 0;
    // every divider keeps the basic clock inside its legal band at 40 MHz
    actc_row_type rows [8] = '{
        '{16'h4400, 12'h155, 10'h155}, '{16'h4000, 12'h2aa, 10'h2aa},
        '{16'h1600, 12'h2af, 10'h2ac}, '{16'he200, 12'h3ff, 10'h3fc},
        '{16'hb400, 12'hffb, 10'h000}, '{16'h7000, 12'h5a5, 10'h3ff},
        '{16'h0802, 12'h001, 10'h001}, '{16'h4200, 12'h7ff, 10'h3ff}};

    actc_top #(.CAL_MAX_BC(600)) i_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .BUS(bus),
        .RDATA(rdata), .ANALOG(analog), .REF_NOISE(ref_noise), .BUSY(busy),
        .CAL_RUNNING(cal_running), .RESULT(result));
    actc_afe_model i_afe (.level(level), .analog(analog));

    // clock and cycle count
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask

    task rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    // expected conversion length in clock cycles
    function int conv_cycles(input logic [15:0] ctl, input int sysf);
        int div;
        int bc;
        div = ctl[11] ? int'(ctl[7:0]) + 1 : (ctl[15:14] == 2'b00) ? 4 :
              (ctl[15:14] == 2'b01) ? 2 : (ctl[15:14] == 2'b10) ? 16 : 8;
        bc = (8 << ctl[13:12]) + (ctl[9] ? 32 : 40) + (ctl[10] ? 12 : 0);
        return (bc * div + 6) * sysf;
    endfunction

    // start one conversion, optionally retrigger it, wait for the end
    task conv(input logic [15:0] ctl, input logic [11:0] vin, input bit poke);
        int n;
        n = 0;
        @(posedge ref_clk);
        level <= vin;
        wr_reg(4'h0, ctl | 16'h0100);
        #1 t0 = cyc;
        if (poke)
        begin
            rd_reg(4'h3, rd_val);
            check("status busy", rd_val, 16'h0001);
            wr_reg(4'h0, ctl | 16'h0100);
        end
        while (busy === 1'b1 && n < 5000)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        d = cyc - t0;
    endtask

    task do_reset(input logic noise);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        ref_noise <= noise;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1 tr = cyc;
        repeat (2) @(posedge ref_clk);
    endtask

    task wait_cal;
        int n;
        n = 0;
        while (cal_running !== 1'b0 && n < 20000)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        d = cyc - tr;
    endtask

    // watchdog against a hang
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        bad_count++;
        test_done;
    end

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        ref_noise = 1'b0;
        bus = '0;
        level = 12'h000;
        do_reset(1'b0);
        rd_reg(4'h0, rd_val);
        check("control reset", rd_val, 16'h0000);
        rd_reg(4'h4, rd_val);
        check("result reset", rd_val, 16'h0000);
        rd_reg(4'h3, rd_val);
        check("status reset", rd_val, 16'h0002);
        rd_reg(4'h6, rd_val);
        check("unmapped read", rd_val, 16'h0000);
        wait_cal;
        check("quiet calibration", 16'(d >= 1936 && d <= 1944), 16'h0001);
        // table of ordinary conversions
        foreach (rows[i])
        begin
            conv(rows[i].ctl, rows[i].vin, 1'b0);
            check("duration", 16'(d), 16'(conv_cycles(rows[i].ctl, 1)));
            check("result", {6'h00, result}, {6'h00, rows[i].res});
        end
        rd_reg(4'h4, rd_val);
        check("result register", rd_val, 16'h03ff);
        // start while busy is ignored
        conv(16'h4000, 12'h2aa, 1'b1);
        check("retrigger duration", 16'(d), 16'(conv_cycles(16'h4000, 1)));
        // master clock modes 0 to 3, cpu halving on in modes 1 and 3 only
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(4'h2, 16'(m));
            wr_reg(4'h1, 16'(m & 1));
            conv(16'h4200, 12'h7ff, 1'b0);
            // a start lands anywhere inside one system period, so up to sf-1 less
            sf = (m == 1 ? 2 : m == 2 ? 4 : 1) * (1 + (m & 1));
            check("clock chain", 16'(d > conv_cycles(16'h4200, sf) - sf &&
                  d <= conv_cycles(16'h4200, sf)), 16'h0001);
        end
        wr_reg(4'h2, 16'h0000);
        wr_reg(4'h1, 16'h0000);
        // noisy reference runs calibration to its limit
        do_reset(1'b1);
        wait_cal;
        check("noisy calibration", 16'(d >= 2400 && d <= 2408), 16'h0001);
        // conversion inside calibration runs and stretches it
        do_reset(1'b0);
        conv(16'h0000, 12'h0f0, 1'b0);
        check("early duration", 16'(d), 16'(conv_cycles(16'h0000, 1)));
        check("early result", {6'h00, result}, 16'h00f0);
        wait_cal;
        check("stretched calibration", 16'(d >= 2130 && d <= 2150), 16'h0001);
        test_done;
    end
endmodule
